//--- rtl/irq_ctrl_pkg.sv
// Purpose: Shared constants and types for the priority interrupt controller.
// Assumes: APB with 32-bit data; register indices are byte offsets divided by four.
// Notes: Vector address of source n is base plus n times the step.
package irq_ctrl_pkg;
    localparam int NUM_SRC = 11;
    localparam int LVL_W = 2;
    localparam int NUM_W = 4;
    localparam int ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_EXT_CTL = 8'h88;
    localparam logic [7:0] IDX_ENABLE_MAIN = 8'ha8;
    localparam logic [7:0] IDX_PRIO_LOW_MAIN = 8'hb8;
    localparam logic [7:0] IDX_PRIO_HIGH_MAIN = 8'hba;
    localparam logic [7:0] IDX_PRIO_HIGH_EXTRA = 8'hbb;
    localparam logic [7:0] IDX_PRIO_LOW_EXTRA = 8'hbc;
    localparam logic [7:0] IDX_ENABLE_EXTRA = 8'hbd;
    localparam logic [7:0] IDX_EXT_CTL_HI = 8'hc0;
    localparam logic [7:0] IDX_STATUS = 8'hf0;
    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_ENABLE_MAIN = 8'hbf;
    localparam logic [7:0] MASK_PRIO_LOW_MAIN = 8'h3f;
    localparam logic [7:0] MASK_EXTRA = 8'h07;
    localparam logic [7:0] MASK_EXT_CTL_HI = 8'hcc;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_EXT2_EN = 2;
    localparam int BIT_EXT2_PLOW = 3;
    localparam int BIT_EXT3_EN = 6;
    localparam int BIT_EXT3_PLOW = 7;
    localparam int BIT_EXT2_PHIGH = 6;
    localparam int BIT_EXT3_PHIGH = 7;
    // Vector numbers
    localparam logic [NUM_W-1:0] VNUM_EXT0 = 4'h0;
    localparam logic [NUM_W-1:0] VNUM_EXT1 = 4'h2;
    localparam logic [NUM_W-1:0] VNUM_TIMER2 = 4'h5;
    localparam logic [NUM_W-1:0] VNUM_EXT2 = 4'h6;
    localparam logic [NUM_W-1:0] VNUM_EXT3 = 4'h7;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_SHIFT = 3;
    // Peripheral flags that feed the requests, some of them shared
    typedef struct packed {
        logic timer2_overflow_flag;
        logic timer2_external_flag;
        logic transmit_done_flag;
        logic receive_done_flag;
        logic timer1_overflow_flag;
        logic timer0_overflow_flag;
        logic brownout_flag;
        logic wake_timer_flag;
        logic serial_periph_done_flag;
        logic serial_periph_overrun_flag;
        logic mode_fault_flag;
    } src_flags_t;
    // Request offered to the core
    typedef struct packed {
        logic [NUM_W-1:0] num;
        logic [15:0] addr;
        logic [LVL_W-1:0] level;
    } vec_t;
endpackage

//--- rtl/priority_interrupt_controller.sv
// Purpose: Four-level priority interrupt controller with eleven sources and APB registers.
// Assumes: Core holds i_irq_ack for one cycle only while o_irq_req is high.
// Notes: APB answers with pready two cycles after setup; one level nests per priority.
// Functional notes
// - Eleven sources are arbitrated over four priority levels.
// - Each source has a flag, enable, priority and fixed vector.
// - Active routine is preempted only by strictly higher enabled pending level.
// - Return instruction ends the active service level; core resumes execution.
// - Ext pin 0 at 0003H, timer 0 at 000BH, ext pin 1 at 0013H.
// - Timer 1 at 001BH, serial port at 0023H, ext pin 2 at 0033H.
// - Timer 2 events share 002BH; ext pin 3 003BH; serial peripheral 0043H.
// - Wake-up timer vectors to 004BH, brown-out to 0053H.
// - Global enable bit 7 blocks all; otherwise each source uses its own enable.
// - Main enable bit 5 gates timer 2 overflow or external flag.
// - Main enable bit 4 gates transmit-done or receive-done request.
// - Main enable bit 3 gates timer 1, bit 1 gates timer 0.
// - Main enable bit 2 gates ext pin 1, bit 0 gates ext pin 0.
// - Extra enable bit 2 gates brown-out, bit 1 wake-up timer; 7:3 reserved.
// - Extra enable bit 0 gates serial peripheral done, overrun or mode fault.
// - Six main sources pair low bits 5:0 with same high-register bits.
// - Ext pins 2 and 3 take high bits 6 and 7; lows in control register.
// - Brown-out, wake-up, serial peripheral low bits 2,1,0 pair with extra high.
// - All enable and priority registers reset to zero.
// - Edge flag clears when its routine starts; level flag is inverse pin.
// - Trigger type 0 is low-level, 1 is falling-edge sensing.
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic [3:0] i_ext_pin_n,
    input wire irq_ctrl_pkg::src_flags_t i_src_flags,
    input wire logic i_irq_ack,
    input wire logic i_return_from_isr_instr,
    output logic o_irq_req,
    output irq_ctrl_pkg::vec_t o_vector,
    output logic [3:0] o_active_levels
);
    import irq_ctrl_pkg::*;

    logic [7:0] enable_main_q, enable_main_d;
    logic [7:0] prio_low_main_q, prio_low_main_d;
    logic [7:0] prio_high_main_q, prio_high_main_d;
    logic [7:0] prio_low_extra_q, prio_low_extra_d;
    logic [7:0] prio_high_extra_q, prio_high_extra_d;
    logic [7:0] enable_extra_q, enable_extra_d;
    logic [7:0] ext_ctl_hi_q, ext_ctl_hi_d;
    logic [3:0] trig_type_q, trig_type_d;
    logic [3:0] ext_flag_q, ext_flag_d;
    logic [3:0] pin_prev_q, pin_prev_d;
    logic [3:0] active_q, active_d;
    logic irq_req_q, irq_req_d;
    vec_t vector_q, vector_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;

    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] src_flag;
    logic [NUM_SRC-1:0] src_req;
    logic [LVL_W-1:0] src_lvl [NUM_SRC];
    logic win_found;
    logic [NUM_W-1:0] win_num;
    logic [LVL_W-1:0] win_lvl;
    logic any_active;
    logic [LVL_W-1:0] cur_lvl;
    logic [7:0] reg_idx;
    logic wr_done;
    logic [3:0] ext_fall;
    logic [7:0] wbyte;
    // Levels in service as they will stand after the coming edge
    logic nxt_any;
    logic [LVL_W-1:0] nxt_lvl;

    // Per-source flag, enable and level, all in vector-number order
    always_comb begin
        src_flag[0] = ext_flag_q[0];
        src_flag[1] = i_src_flags.timer0_overflow_flag;
        src_flag[2] = ext_flag_q[1];
        src_flag[3] = i_src_flags.timer1_overflow_flag;
        src_flag[4] = i_src_flags.transmit_done_flag | i_src_flags.receive_done_flag;
        src_flag[5] = i_src_flags.timer2_overflow_flag | i_src_flags.timer2_external_flag;
        src_flag[6] = ext_flag_q[2];
        src_flag[7] = ext_flag_q[3];
        src_flag[8] = i_src_flags.serial_periph_done_flag
            | i_src_flags.serial_periph_overrun_flag | i_src_flags.mode_fault_flag;
        src_flag[9] = i_src_flags.wake_timer_flag;
        src_flag[10] = i_src_flags.brownout_flag;
        // Main register bits 5:0 map onto the six main sources in vector order
        src_en[5:0] = enable_main_q[5:0];
        src_en[6] = ext_ctl_hi_q[BIT_EXT2_EN];
        src_en[7] = ext_ctl_hi_q[BIT_EXT3_EN];
        src_en[10:8] = enable_extra_q[2:0];
        for (int i = 0; i < 6; i++) begin
            src_lvl[i] = {prio_high_main_q[i], prio_low_main_q[i]};
        end
        src_lvl[6] = {prio_high_main_q[BIT_EXT2_PHIGH], ext_ctl_hi_q[BIT_EXT2_PLOW]};
        src_lvl[7] = {prio_high_main_q[BIT_EXT3_PHIGH], ext_ctl_hi_q[BIT_EXT3_PLOW]};
        for (int i = 0; i < 3; i++) begin
            src_lvl[8 + i] = {prio_high_extra_q[i], prio_low_extra_q[i]};
        end
        // Global enable overrides every individual mask
        src_req = src_flag & src_en & {NUM_SRC{enable_main_q[BIT_GLOBAL_EN]}};
    end

    // Arbitration: highest level wins, lowest number breaks a tie
    always_comb begin
        win_found = 1'b0;
        win_num = '0;
        win_lvl = '0;
        // Scanning downward with >= leaves the lowest number among equals
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (src_req[i] && (!win_found || src_lvl[i] >= win_lvl)) begin
                win_found = 1'b1;
                win_num = NUM_W'(i);
                win_lvl = src_lvl[i];
            end
        end
        any_active = |active_q;
        cur_lvl = '0;
        for (int l = 0; l < 4; l++) begin
            if (active_q[l]) begin
                cur_lvl = LVL_W'(l);
            end
        end
    end

    // Bus decode and external pin edge sensing
    // Pin history resets high so a low pin after reset reads as a real edge
    always_comb begin
        reg_idx = i_paddr[9:2];
        wr_done = i_psel & i_penable & i_pwrite & pready_q;
        wbyte = i_pwdata[7:0];
        ext_fall = pin_prev_q & ~i_ext_pin_n;
    end

    // Next-state logic for registers, flags, nesting and bus answer
    always_comb begin
        enable_main_d = enable_main_q;
        prio_low_main_d = prio_low_main_q;
        prio_high_main_d = prio_high_main_q;
        prio_low_extra_d = prio_low_extra_q;
        prio_high_extra_d = prio_high_extra_q;
        enable_extra_d = enable_extra_q;
        ext_ctl_hi_d = ext_ctl_hi_q;
        trig_type_d = trig_type_q;
        ext_flag_d = ext_flag_q;
        pin_prev_d = i_ext_pin_n;
        active_d = active_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        // Registered pready adds one wait state so read data comes from a flop
        pready_d = i_psel & i_penable & ~pready_q;
        if (wr_done) begin
            case (reg_idx)
                IDX_ENABLE_MAIN: enable_main_d = wbyte & MASK_ENABLE_MAIN;
                IDX_PRIO_LOW_MAIN: prio_low_main_d = wbyte & MASK_PRIO_LOW_MAIN;
                IDX_PRIO_HIGH_MAIN: prio_high_main_d = wbyte;
                IDX_PRIO_LOW_EXTRA: prio_low_extra_d = wbyte & MASK_EXTRA;
                IDX_PRIO_HIGH_EXTRA: prio_high_extra_d = wbyte & MASK_EXTRA;
                IDX_ENABLE_EXTRA: enable_extra_d = wbyte & MASK_EXTRA;
                IDX_EXT_CTL: begin
                    trig_type_d[1:0] = {wbyte[2], wbyte[0]};
                    ext_flag_d[1:0] = {wbyte[3], wbyte[1]};
                end
                IDX_EXT_CTL_HI: begin
                    ext_ctl_hi_d = wbyte & MASK_EXT_CTL_HI;
                    trig_type_d[3:2] = {wbyte[4], wbyte[0]};
                    ext_flag_d[3:2] = {wbyte[5], wbyte[1]};
                end
                default: ;
            endcase
        end
        // Read data and error are formed in the wait cycle, shown with pready
        if (i_psel && i_penable && !pready_q) begin
            prdata_d = '0;
            case (reg_idx)
                IDX_ENABLE_MAIN: prdata_d[7:0] = enable_main_q;
                IDX_PRIO_LOW_MAIN: prdata_d[7:0] = prio_low_main_q;
                IDX_PRIO_HIGH_MAIN: prdata_d[7:0] = prio_high_main_q;
                IDX_PRIO_LOW_EXTRA: prdata_d[7:0] = prio_low_extra_q;
                IDX_PRIO_HIGH_EXTRA: prdata_d[7:0] = prio_high_extra_q;
                IDX_ENABLE_EXTRA: prdata_d[7:0] = enable_extra_q;
                IDX_EXT_CTL: prdata_d[3:0] = {ext_flag_q[1], trig_type_q[1],
                    ext_flag_q[0], trig_type_q[0]};
                IDX_EXT_CTL_HI: prdata_d[7:0] = ext_ctl_hi_q | {2'b00, ext_flag_q[3],
                    trig_type_q[3], 2'b00, ext_flag_q[2], trig_type_q[2]};
                IDX_STATUS: prdata_d[8:0] = {irq_req_q, vector_q.num, active_q};
                default: pslverr_d = 1'b1;
            endcase
        end
        // External flags: level mode tracks the pin, edge mode is sticky
        for (int e = 0; e < 4; e++) begin
            if (!trig_type_d[e]) begin
                ext_flag_d[e] = ~i_ext_pin_n[e];
            end else begin
                if (i_irq_ack && irq_req_q && vector_q.num == ext_num(e)) begin
                    ext_flag_d[e] = 1'b0;
                end
                if (ext_fall[e]) begin
                    ext_flag_d[e] = 1'b1; // Set wins over any clear
                end
            end
        end
        // Return drops the top level before a same-cycle acceptance is added
        if (i_return_from_isr_instr && any_active) begin
            active_d[cur_lvl] = 1'b0;
        end
        if (i_irq_ack && irq_req_q) begin
            active_d[vector_q.level] = 1'b1;
        end
        // Judge against the levels after this edge: an accepted request is then
        // not offered again while its own level is being set
        nxt_any = |active_d;
        nxt_lvl = '0;
        for (int l = 0; l < 4; l++) begin
            if (active_d[l]) begin
                nxt_lvl = LVL_W'(l);
            end
        end
        // Offer only a request that beats every level in service
        irq_req_d = win_found && (!nxt_any || win_lvl > nxt_lvl);
        vector_d.num = win_num;
        vector_d.level = win_lvl;
        vector_d.addr = VEC_BASE + (16'(win_num) << VEC_SHIFT);
    end

    // Vector number of each external pin source; the four pins are not
    // numbered in a row, so a lookup keeps the flag clear on the right vector
    function automatic logic [NUM_W-1:0] ext_num(input int e);
        case (e)
            0: ext_num = VNUM_EXT0;
            1: ext_num = VNUM_EXT1;
            2: ext_num = VNUM_EXT2;
            default: ext_num = VNUM_EXT3;
        endcase
    endfunction

    // State registers; clock enable low freezes everything
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            enable_main_q <= REG_RESET;
            prio_low_main_q <= REG_RESET;
            prio_high_main_q <= REG_RESET;
            prio_low_extra_q <= REG_RESET;
            prio_high_extra_q <= REG_RESET;
            enable_extra_q <= REG_RESET;
            ext_ctl_hi_q <= REG_RESET;
            trig_type_q <= '0;
            ext_flag_q <= '0;
            pin_prev_q <= '1;
            active_q <= '0;
            irq_req_q <= 1'b0;
            vector_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (i_clk_en) begin
            enable_main_q <= enable_main_d;
            prio_low_main_q <= prio_low_main_d;
            prio_high_main_q <= prio_high_main_d;
            prio_low_extra_q <= prio_low_extra_d;
            prio_high_extra_q <= prio_high_extra_d;
            enable_extra_q <= enable_extra_d;
            ext_ctl_hi_q <= ext_ctl_hi_d;
            trig_type_q <= trig_type_d;
            ext_flag_q <= ext_flag_d;
            pin_prev_q <= pin_prev_d;
            active_q <= active_d;
            irq_req_q <= irq_req_d;
            vector_q <= vector_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Outputs straight from flops
    always_comb begin
        o_pready = pready_q;
        o_prdata = prdata_q;
        o_pslverr = pslverr_q;
        o_irq_req = irq_req_q;
        o_vector = vector_q;
        o_active_levels = active_q;
    end

    // Checks run on the system clock and are quiet while reset is low
    // Antecedents of the next-cycle checks carry the clock enable since a frozen cycle changes nothing
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    global_gate_a: assert property ((i_clk_en && !enable_main_q[BIT_GLOBAL_EN])
        |=> !o_irq_req) else $error("request offered while globally disabled");
    vector_addr_a: assert property (o_irq_req |->
        o_vector.addr == VEC_BASE + (16'(o_vector.num) << VEC_SHIFT))
        else $error("vector address does not match number");
    // A return in the same cycle may legally let the waiting request through
    no_preempt_a: assert property ((i_clk_en && any_active && win_lvl <= cur_lvl
        && !i_return_from_isr_instr)
        |=> !o_irq_req) else $error("equal or lower level preempted routine");
    return_pops_a: assert property ((i_clk_en && i_return_from_isr_instr && !i_irq_ack
        && any_active) |=> $countones(active_q) == $countones($past(active_q)) - 1)
        else $error("return did not end one service level");
    ack_level_a: assert property ((i_clk_en && i_irq_ack && o_irq_req
        && !i_return_from_isr_instr) |=> active_q[$past(o_vector.level)])
        else $error("accepted level not marked active");
    edge_clear_a: assert property ((i_clk_en && i_irq_ack && o_irq_req && trig_type_q[0]
        && o_vector.num == VNUM_EXT0 && !ext_fall[0]) |=> !ext_flag_q[0])
        else $error("edge flag not cleared on entry");
    level_follow_a: assert property ((i_clk_en && !trig_type_q[1] && !wr_done)
        |=> ext_flag_q[1] == !$past(i_ext_pin_n[1]))
        else $error("level flag does not follow pin");
    reset_zero_a: assert property ($past(!i_resetn) |-> enable_main_q == REG_RESET
        && prio_high_main_q == REG_RESET && enable_extra_q == REG_RESET)
        else $error("registers not zero after reset");
    // An acceptance in the same cycle marks the level and rightly drops the offer
    timer2_req_a: assert property ((i_clk_en && src_req == 11'h020 && !any_active
        && !i_irq_ack)
        |=> o_irq_req && o_vector.num == VNUM_TIMER2)
        else $error("timer 2 request not offered");
    tie_low_a: assert property ((i_clk_en && src_req == 11'h003 && src_lvl[0] == src_lvl[1]
        && !any_active) |=> o_vector.num == VNUM_EXT0)
        else $error("tie not resolved to lowest number");

    // Main scenarios: nesting, return from two levels, edge capture, top level, drop
    nested_c: cover property (o_irq_req && any_active && i_irq_ack);
    ack_drop_c: cover property (o_irq_req && i_irq_ack ##1 !o_irq_req);
    return_c: cover property (i_return_from_isr_instr && active_q == 4'h3);
    edge_set_c: cover property (trig_type_q[2] && ext_fall[2]);
    top_level_c: cover property (o_irq_req && o_vector.level == 2'h3);
endmodule
`default_nettype wire

//--- tb/core_model.sv
// Purpose: Behavioural processor core that takes offered vectors and returns from routines.
// Assumes: The bench steers when vectors are taken, how late, and when a routine ends.
// Notes: Returns are issued only while a routine is in service.
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_irq_req,
    input wire logic i_take,
    input wire logic [3:0] i_lat,
    input wire logic i_ret_cmd,
    output logic o_ack,
    output logic o_ret
);
    logic [3:0] cnt_q;
    logic [3:0] depth_q;
    // Ack after i_lat cycles; idle one cycle after an ack so the old request is not taken twice
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cnt_q <= 4'h0;
            depth_q <= 4'h0;
            o_ack <= 1'b0;
            o_ret <= 1'b0;
        end else begin
            o_ret <= i_ret_cmd && (depth_q != 4'h0);
            if (o_ack) begin
                o_ack <= 1'b0;
                cnt_q <= 4'h0;
                depth_q <= depth_q + 4'h1;
            end else if (i_irq_req && i_take) begin
                o_ack <= (cnt_q == i_lat);
                cnt_q <= cnt_q + 4'h1;
            end else if (o_ret) begin
                depth_q <= depth_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/priority_interrupt_controller_tb.sv
// Purpose: Self-checking bench for the priority interrupt controller.
// Assumes: Core model takes vectors; bench drives APB, pins and peripheral flags.
// Notes: Every wait is bounded; one that runs out ends the run as a mismatch.
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller_tb;
    import irq_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] pin_n = 4'hf;
    src_flags_t flags = '0;
    logic ack;
    logic ret;
    logic take = 1'b0;
    logic ret_cmd = 1'b0;
    logic [3:0] lat = 4'h0;
    logic irq_req;
    vec_t vec;
    logic [3:0] active;
    int err_total = 0;
    int checks = 0;
    logic [15:0] vaddr [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
                                16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
    logic [7:0] ridx [6] = '{IDX_ENABLE_MAIN, IDX_PRIO_LOW_MAIN, IDX_PRIO_HIGH_MAIN,
                             IDX_PRIO_LOW_EXTRA, IDX_ENABLE_EXTRA, IDX_PRIO_HIGH_EXTRA};
    logic [7:0] rmask [6] = '{8'hbf, 8'h3f, 8'hff, 8'h07, 8'h07, 8'h07};

    priority_interrupt_controller DUT (
        .i_clk_sys(clk_sys), .i_resetn(resetn), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_ext_pin_n(pin_n), .i_src_flags(flags), .i_irq_ack(ack),
        .i_return_from_isr_instr(ret), .o_irq_req(irq_req), .o_vector(vec),
        .o_active_levels(active));
    core_model core (
        .i_clk_sys(clk_sys), .i_resetn(resetn), .i_irq_req(irq_req), .i_take(take),
        .i_lat(lat), .i_ret_cmd(ret_cmd), .o_ack(ack), .o_ret(ret));

    // 250 MHz clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic expired(input string name);
        err_total++;
        $display("Error %s expected answer seen timeout", name);
        close_out();
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 20) expired("bus answer");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, idx, d, q, e);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        apb(1'b0, idx, 8'h00, q, e);
        chk("read data", exp, q);
        chk("slave error", 32'(exp_err), 32'(e));
    endtask

    task automatic wait_req(input logic v);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (irq_req === v) break;
        end
        if (n == 20) expired("request");
    endtask

    // Sub-enables first and the main register last, so no source slips through meanwhile
    task automatic set_en(input logic g, input logic [10:0] en);
        wr(IDX_EXT_CTL_HI, {1'b0, en[7], 3'b000, en[6], 2'b00});
        wr(IDX_ENABLE_EXTRA, {5'h00, en[10:8]});
        wr(IDX_ENABLE_MAIN, {g, 1'b0, en[5:0]});
    endtask

    task automatic src(input int n, input int a);
        case (n)
            0: pin_n[0] <= 1'b0;
            1: flags.timer0_overflow_flag <= 1'b1;
            2: pin_n[1] <= 1'b0;
            3: flags.timer1_overflow_flag <= 1'b1;
            4: {flags.transmit_done_flag, flags.receive_done_flag} <= 2'b10 >> (a > 0);
            5: {flags.timer2_overflow_flag, flags.timer2_external_flag} <= 2'b10 >> (a > 0);
            6: pin_n[2] <= 1'b0;
            7: pin_n[3] <= 1'b0;
            8: {flags.serial_periph_done_flag, flags.serial_periph_overrun_flag,
                flags.mode_fault_flag} <= 3'b100 >> a;
            9: flags.wake_timer_flag <= 1'b1;
            default: flags.brownout_flag <= 1'b1;
        endcase
    endtask

    task automatic clear();
        @(posedge clk_sys);
        flags <= '0;
        pin_n <= 4'hf;
    endtask

    task automatic take_chk(input logic [3:0] exp);
        @(posedge clk_sys);
        take <= 1'b1;
        wait_req(1'b0);
        take <= 1'b0;
        chk("active levels", 32'(exp), 32'(active));
    endtask

    task automatic ret_chk(input logic [3:0] exp);
        @(posedge clk_sys);
        ret_cmd <= 1'b1;
        @(posedge clk_sys);
        ret_cmd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("active levels", 32'(exp), 32'(active));
    endtask

    // Reset values, reserved bits and an unmapped index
    task automatic regs();
        for (int i = 0; i < 6; i++) begin
            rchk(ridx[i], 32'h0, 1'b0);
            wr(ridx[i], 8'hff);
            rchk(ridx[i], 32'(rmask[i]), 1'b0);
            wr(ridx[i], 8'h00);
        end
        rchk(8'h01, 32'h0, 1'b1);
    endtask

    // Every source and every shared flag: gating by global and own enable, then its vector
    task automatic sources();
        for (int n = 0; n < NUM_SRC; n++) begin
            for (int a = 0; a < 3; a++) begin
                set_en(1'b0, 11'h7ff);
                @(posedge clk_sys);
                src(n, a);
                repeat (3) @(posedge clk_sys);
                chk("global off", 32'h0, 32'(irq_req));
                set_en(1'b1, ~(11'h001 << n));
                repeat (2) @(posedge clk_sys);
                chk("own enable off", 32'h0, 32'(irq_req));
                set_en(1'b1, 11'h7ff);
                wait_req(1'b1);
                chk("vector number", 32'(n), 32'(vec.num));
                chk("vector address", 32'(vaddr[n]), 32'(vec.addr));
                clear();
                wait_req(1'b0);
            end
        end
        set_en(1'b0, 11'h000);
    endtask

    // Tie break, a lower level left waiting, preemption by a higher level, and nested returns
    task automatic nesting();
        lat <= 4'h2;
        set_en(1'b1, 11'h00a);
        @(posedge clk_sys);
        flags.timer0_overflow_flag <= 1'b1;
        flags.timer1_overflow_flag <= 1'b1;
        wait_req(1'b1);
        chk("tie winner", 32'({4'h1, 2'h0}), 32'({vec.num, vec.level}));
        wr(IDX_PRIO_HIGH_MAIN, 8'h08);
        repeat (2) @(posedge clk_sys);
        chk("raised winner", 32'({4'h3, 2'h2}), 32'({vec.num, vec.level}));
        take_chk(4'h4);
        wr(IDX_PRIO_LOW_MAIN, 8'h02);
        repeat (2) @(posedge clk_sys);
        chk("lower waits", 32'h0, 32'(irq_req));
        wr(IDX_PRIO_HIGH_MAIN, 8'h0a);
        wait_req(1'b1);
        chk("preempting", 32'({4'h1, 2'h3}), 32'({vec.num, vec.level}));
        take_chk(4'hc);
        ret_chk(4'h4);
        clear();
        ret_chk(4'h0);
        wr(IDX_PRIO_HIGH_MAIN, 8'h00);
        wr(IDX_PRIO_LOW_MAIN, 8'h00);
    endtask

    // Falling-edge mode: one short pulse is held, then cleared when its routine starts
    task automatic edge_mode();
        lat <= 4'h0;
        wr(IDX_EXT_CTL, 8'h01);
        set_en(1'b1, 11'h001);
        @(posedge clk_sys);
        pin_n[0] <= 1'b0;
        @(posedge clk_sys);
        pin_n[0] <= 1'b1;
        wait_req(1'b1);
        rchk(IDX_STATUS, 32'h100, 1'b0);
        rchk(IDX_EXT_CTL, 32'h03, 1'b0);
        take_chk(4'h1);
        rchk(IDX_EXT_CTL, 32'h01, 1'b0);
        ret_chk(4'h0);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        regs();
        sources();
        nesting();
        edge_mode();
        close_out();
    end
endmodule
`default_nettype wire
